// >>> design/link_host_params.svh
`ifndef LINK_HOST_PARAMS_SVH
`define LINK_HOST_PARAMS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define ADDR_W            8
`define OFS_VERSION       8'h00
`define OFS_ROM_ACCESS    8'h04
`define OFS_RETRY         8'h08
`define OFS_CS_DATA       8'h0C
`define OFS_CS_COMPARE    8'h10
`define OFS_CS_CONTROL    8'h14
`define OFS_ROM_HEADER    8'h18

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define VER_PRESENT_BIT   24
`define VER_MAJOR_LSB     16
`define ROM_CLEAR_BIT     31
`define ROM_GO_BIT        25
`define ROM_BYTE_LSB      16
`define CS_DONE_BIT       31

// ----------------------------------------------------------------------
// reset values and constants
// ----------------------------------------------------------------------
`define MINI_ROM_RESET    8'h00
`define MINI_ROM_WORD     8'h28
`define MINI_ROM_LIMIT    8'h39
`define RETRY_RESET       12'h000
`define CS_DONE_RESET     1'b1
`define CS_SEL_RESET      2'h0
`define HEADER_RESET      32'h00000000
`define RESOURCE_RESET    32'hFFFFFFFF
`define BOOT_SETTLE       2'h3

`endif

// >>> design/link_host_pkg.sv
package link_host_pkg;
    `include "link_host_params.svh"

    typedef enum logic [1:0] {BOOT_SETTLE, BOOT_FETCH, BOOT_RUN}
        boot_state_type;
    typedef enum logic [1:0] {PORT_IDLE, PORT_WAIT_ACK, PORT_RELEASE}
        port_state_type;
    typedef enum logic {CS_IDLE, CS_EXEC} cs_state_type;

    typedef struct packed {
        boot_state_type boot;
        logic [1:0]     settle;
        logic           present;
        logic [7:0]     mini;
        logic [7:0]     rom_addr;
        logic [7:0]     rom_byte;
        logic           go;
        logic           clr;
        logic           rom_start;
        logic [11:0]    retry;
        logic [31:0]    cs_data;
        logic [31:0]    cs_cmp;
        logic [1:0]     cs_sel;
        logic           cs_done;
        logic           cs_start;
        logic [31:0]    hdr;
        logic [31:0]    rdata;
        logic           rvalid;
    } regs_state_type;

    typedef struct packed {
        port_state_type st;
        logic           ack_s1;
        logic           ack_s2;
        logic           pres_s1;
        logic           pres_s2;
        logic [7:0]     data_s1;
        logic [7:0]     data_s2;
        logic           req;
        logic [7:0]     addr;
        logic [7:0]     data;
        logic           done;
    } port_state_type_s_type;

    typedef struct packed {
        cs_state_type    st;
        logic [1:0]      sel;
        logic [3:0][31:0] res;
        logic [31:0]     prior;
        logic            done;
    } swap_state_type;
endpackage

// >>> design/serial_rom_port.sv
`timescale 1ns/1ps
`include "link_host_params.svh"

module serial_rom_port (
    input  wire logic       i_ref_clk,
    input  wire logic       i_rstn,
    input  wire logic       i_start,
    input  wire logic [7:0] i_addr,
    output logic            o_done,
    output logic [7:0]      o_data,
    output logic            o_present,
    output logic            o_rom_req,
    output logic [7:0]      o_rom_addr,
    input  wire logic       i_rom_ack,
    input  wire logic [7:0] i_rom_data,
    input  wire logic       i_rom_present
);
    link_host_pkg::port_state_type_s_type s_reg;
    link_host_pkg::port_state_type_s_type s_next;

    // ------------------------------------------------------------------
    // four-phase byte fetch, pins synchronised
    // ------------------------------------------------------------------
    always_comb begin
        s_next         = s_reg;
        s_next.ack_s1  = i_rom_ack;
        s_next.ack_s2  = s_reg.ack_s1;
        s_next.pres_s1 = i_rom_present;
        s_next.pres_s2 = s_reg.pres_s1;
        s_next.data_s1 = i_rom_data;
        s_next.data_s2 = s_reg.data_s1;
        s_next.done    = 1'b0;
        unique case (s_reg.st)
            link_host_pkg::PORT_IDLE: begin
                if (i_start) begin
                    s_next.req  = 1'b1;
                    s_next.addr = i_addr;
                    s_next.st   = link_host_pkg::PORT_WAIT_ACK;
                end
            end
            link_host_pkg::PORT_WAIT_ACK: begin
                if (s_reg.ack_s2) begin
                    s_next.data = s_reg.data_s2;
                    s_next.req  = 1'b0;
                    s_next.st   = link_host_pkg::PORT_RELEASE;
                end
            end
            link_host_pkg::PORT_RELEASE: begin
                if (!s_reg.ack_s2) begin
                    s_next.done = 1'b1;
                    s_next.st   = link_host_pkg::PORT_IDLE;
                end
            end
            default: s_next.st = link_host_pkg::PORT_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_done     = s_reg.done;
    assign o_data     = s_reg.data;
    assign o_present  = s_reg.pres_s2;
    assign o_rom_req  = s_reg.req;
    assign o_rom_addr = s_reg.addr;
endmodule

// >>> design/compare_swap_unit.sv
`timescale 1ns/1ps
`include "link_host_params.svh"

module compare_swap_unit (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_start,
    input  wire logic [1:0]  i_sel,
    input  wire logic [31:0] i_compare,
    input  wire logic [31:0] i_swap,
    output logic             o_done,
    output logic [31:0]      o_prior
);
    link_host_pkg::swap_state_type s_reg;
    link_host_pkg::swap_state_type s_next;

    // ------------------------------------------------------------------
    // 00 manager id, 01 bandwidth, 10 channels hi, 11 channels lo
    // ------------------------------------------------------------------
    always_comb begin
        s_next      = s_reg;
        s_next.done = 1'b0;
        unique case (s_reg.st)
            link_host_pkg::CS_IDLE: begin
                if (i_start) begin
                    s_next.sel = i_sel;
                    s_next.st  = link_host_pkg::CS_EXEC;
                end
            end
            link_host_pkg::CS_EXEC: begin
                s_next.prior = s_reg.res[s_reg.sel];
                if (s_reg.res[s_reg.sel] == i_compare) begin
                    s_next.res[s_reg.sel] = i_swap;
                end
                s_next.done = 1'b1;
                s_next.st   = link_host_pkg::CS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_reg     <= '0;
            s_reg.res <= {4{`RESOURCE_RESET}};
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_done  = s_reg.done;
    assign o_prior = s_reg.prior;
endmodule

// >>> design/link_host_config_regs.sv
`timescale 1ns/1ps
`include "link_host_params.svh"

// Functional notes
// - version bit 24 shows an EEPROM; boot then loads its info.
// - version returns fixed major and minor fields, other bits zero except bit 24.
// - EEPROM access register acts only while the EEPROM flag is set.
// - address-clear zeroes the byte address then self-clears, no fetch.
// - read-go fetches the addressed byte, loads it, then self-clears.
// - mini-ROM offset resets to zero, loaded from EEPROM word 28h.
// - mini-ROM offset is valid only when above 39h.
// - dual-phase second and cycle limit fields read zero.
// - physical response retry count field, default zero.
// - async transmit response retry count field, default zero.
// - async transmit request retry count field, default zero.
// - compare-swap data holds the swap value, then the prior resource value on completion.
// - compare-swap compare holds the value checked against resource.
// - done sets on completion, clears on a control write unless completion lands in the same cycle.
// - select 00 manager id, 01 bandwidth, 10/11 channels hi/lo.
// - control resets with done set, reserved zero.
// - header register is the first configuration ROM quadlet.
// - hardware-reset bits return to defaults on any system reset.
// - zero retry register forces store-and-forward transmit.

module link_host_config_regs #(
    parameter logic [7:0] VERSION_MAJOR = 8'h0A, // arbitrary value
    parameter logic [7:0] VERSION_MINOR = 8'h05  // arbitrary value
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [31:0] i_reg_wdata,
    output logic [31:0]      o_reg_rdata,
    output logic             o_reg_rvalid,
    input  wire logic        i_rom_present,
    output logic             o_rom_req,
    output logic [7:0]       o_rom_addr,
    input  wire logic        i_rom_ack,
    input  wire logic [7:0]  i_rom_data,
    output logic [3:0]       o_phys_response_retry_count,
    output logic [3:0]       o_async_response_retry_count,
    output logic [3:0]       o_async_request_retry_count,
    output logic             o_store_and_forward,
    output logic [7:0]       o_mini_rom_offset,
    output logic             o_mini_rom_valid,
    output logic [31:0]      o_rom_header,
    output logic             o_boot_done
);
    link_host_pkg::regs_state_type s_reg;
    link_host_pkg::regs_state_type s_next;

    logic        rom_done;
    logic [7:0]  rom_data;
    logic        rom_present_sync;
    logic [7:0]  rom_fetch_addr;
    logic        cs_done_pulse;
    logic [31:0] cs_prior;
    logic [31:0] rd_mux;

    // ------------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------------
    assign rom_fetch_addr = (s_reg.boot == link_host_pkg::BOOT_RUN) ?
                            s_reg.rom_addr : `MINI_ROM_WORD;

    serial_rom_port u_rom (
        .i_ref_clk     (i_ref_clk),
        .i_rstn        (i_rstn),
        .i_start       (s_reg.rom_start),
        .i_addr        (rom_fetch_addr),
        .o_done        (rom_done),
        .o_data        (rom_data),
        .o_present     (rom_present_sync),
        .o_rom_req     (o_rom_req),
        .o_rom_addr    (o_rom_addr),
        .i_rom_ack     (i_rom_ack),
        .i_rom_data    (i_rom_data),
        .i_rom_present (i_rom_present)
    );

    compare_swap_unit u_swap (
        .i_ref_clk (i_ref_clk),
        .i_rstn    (i_rstn),
        .i_start   (s_reg.cs_start),
        .i_sel     (s_reg.cs_sel),
        .i_compare (s_reg.cs_cmp),
        .i_swap    (s_reg.cs_data),
        .o_done    (cs_done_pulse),
        .o_prior   (cs_prior)
    );

    // ------------------------------------------------------------------
    // read multiplexer
    // ------------------------------------------------------------------
    always_comb begin
        rd_mux = 32'h00000000;
        unique case (i_reg_addr)
            `OFS_VERSION: begin
                rd_mux[`VER_PRESENT_BIT] = s_reg.present;
                rd_mux[23:16] = VERSION_MAJOR;
                rd_mux[7:0]   = VERSION_MINOR;
            end
            `OFS_ROM_ACCESS: begin
                rd_mux[`ROM_CLEAR_BIT] = s_reg.clr;
                rd_mux[`ROM_GO_BIT]    = s_reg.go;
                rd_mux[23:16]          = s_reg.rom_byte;
                rd_mux[7:0]            = s_reg.mini;
            end
            // upper twenty bits stay zero
            `OFS_RETRY:      rd_mux[11:0] = s_reg.retry;
            `OFS_CS_DATA:    rd_mux = s_reg.cs_data;
            `OFS_CS_COMPARE: rd_mux = s_reg.cs_cmp;
            `OFS_CS_CONTROL: begin
                rd_mux[`CS_DONE_BIT] = s_reg.cs_done;
                rd_mux[1:0]          = s_reg.cs_sel;
            end
            `OFS_ROM_HEADER: rd_mux = s_reg.hdr;
            default:         rd_mux = 32'h00000000;
        endcase
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        s_next           = s_reg;
        s_next.rom_start = 1'b0;
        s_next.cs_start  = 1'b0;
        s_next.rvalid    = i_reg_rd;
        if (i_reg_rd) begin
            s_next.rdata = rd_mux;
        end

        // boot: catch presence, fetch mini-ROM offset
        unique case (s_reg.boot)
            link_host_pkg::BOOT_SETTLE: begin
                if (s_reg.settle == `BOOT_SETTLE) begin
                    s_next.present = rom_present_sync;
                    if (rom_present_sync) begin
                        s_next.rom_start = 1'b1;
                        s_next.boot = link_host_pkg::BOOT_FETCH;
                    end else begin
                        s_next.boot = link_host_pkg::BOOT_RUN;
                    end
                end else begin
                    s_next.settle = s_reg.settle + 2'h1;
                end
            end
            link_host_pkg::BOOT_FETCH: begin
                if (rom_done) begin
                    s_next.mini = rom_data;
                    s_next.boot = link_host_pkg::BOOT_RUN;
                end
            end
            link_host_pkg::BOOT_RUN: begin
                if (s_reg.clr && !s_reg.go) begin
                    s_next.rom_addr = 8'h00;
                    s_next.clr      = 1'b0;
                end
                if (s_reg.go && rom_done) begin
                    s_next.rom_byte = rom_data;
                    s_next.go       = 1'b0;
                    s_next.rom_addr = s_reg.rom_addr + 8'h01;
                end
            end
            default: s_next.boot = link_host_pkg::BOOT_SETTLE;
        endcase

        if (i_reg_wr) begin
            unique case (i_reg_addr)
                `OFS_ROM_ACCESS: begin
                    if (s_reg.present &&
                        s_reg.boot == link_host_pkg::BOOT_RUN) begin
                        if (i_reg_wdata[`ROM_CLEAR_BIT]) begin
                            s_next.clr = 1'b1;
                        end
                        if (i_reg_wdata[`ROM_GO_BIT] && !s_reg.go) begin
                            s_next.go        = 1'b1;
                            s_next.rom_start = 1'b1;
                        end
                    end
                end
                `OFS_RETRY: begin
                    s_next.retry = i_reg_wdata[11:0];
                end
                `OFS_CS_DATA:    s_next.cs_data = i_reg_wdata;
                `OFS_CS_COMPARE: s_next.cs_cmp = i_reg_wdata;
                `OFS_CS_CONTROL: begin
                    s_next.cs_sel   = i_reg_wdata[1:0];
                    s_next.cs_done  = 1'b0;
                    s_next.cs_start = 1'b1;
                end
                `OFS_ROM_HEADER: s_next.hdr = i_reg_wdata;
                default: begin
                end
            endcase
        end

        // completion wins over a clearing write
        if (cs_done_pulse) begin
            s_next.cs_data = cs_prior;
            s_next.cs_done = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_reg         <= '0;
            s_reg.boot    <= link_host_pkg::BOOT_SETTLE;
            s_reg.mini    <= `MINI_ROM_RESET;
            s_reg.retry   <= `RETRY_RESET;
            s_reg.cs_done <= `CS_DONE_RESET;
            s_reg.cs_sel  <= `CS_SEL_RESET;
            s_reg.hdr     <= `HEADER_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign o_reg_rdata                  = s_reg.rdata;
    assign o_reg_rvalid                 = s_reg.rvalid;
    assign o_phys_response_retry_count  = s_reg.retry[11:8];
    assign o_async_response_retry_count = s_reg.retry[7:4];
    assign o_async_request_retry_count  = s_reg.retry[3:0];
    assign o_store_and_forward = (s_reg.retry == 12'h000);
    assign o_mini_rom_offset   = s_reg.mini;
    assign o_mini_rom_valid    = (s_reg.mini > `MINI_ROM_LIMIT);
    assign o_rom_header        = s_reg.hdr;
    assign o_boot_done = (s_reg.boot == link_host_pkg::BOOT_RUN);

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    sequence ctrl_write;
        i_reg_wr && i_reg_addr == `OFS_CS_CONTROL;
    endsequence

    sequence reg_read(logic [7:0] a);
        i_reg_rd && i_reg_addr == a;
    endsequence

    AST_VERSION_FIXED: assert property (
        reg_read(`OFS_VERSION) |=> o_reg_rvalid && o_reg_rdata[31:25] == 7'h00
        && o_reg_rdata[23:16] == VERSION_MAJOR && o_reg_rdata[15:8] == 8'h00
        && o_reg_rdata[7:0] == VERSION_MINOR)
        else $error("version register value wrong");

    AST_RETRY_HIGH_ZERO: assert property (
        reg_read(`OFS_RETRY) |=> o_reg_rdata[31:12] == 20'h00000)
        else $error("retry register upper bits not zero");

    AST_RETRY_FIELDS: assert property (
        i_reg_wr && i_reg_addr == `OFS_RETRY |=>
        o_phys_response_retry_count == $past(i_reg_wdata[11:8]) &&
        o_async_response_retry_count == $past(i_reg_wdata[7:4]) &&
        o_async_request_retry_count == $past(i_reg_wdata[3:0]))
        else $error("retry fields not taken from write");

    AST_STORE_FORWARD: assert property (
        i_reg_wr && i_reg_addr == `OFS_RETRY && i_reg_wdata[11:0] == 12'h000
        && !$past(i_reg_wr) |=> o_store_and_forward)
        else $error("zero retries without store-and-forward");

    AST_DONE_CLEAR: assert property (
        ctrl_write and !cs_done_pulse |=> !s_reg.cs_done)
        else $error("control write did not clear done");

    AST_SWAP_COMPLETES: assert property (
        ctrl_write and s_reg.cs_done |=> ##[1:4] s_reg.cs_done)
        else $error("compare-swap did not complete");

    AST_ADDR_CLEAR: assert property (
        s_reg.clr && !s_reg.go && s_reg.boot == link_host_pkg::BOOT_RUN |=>
        s_reg.rom_addr == 8'h00 && s_reg.rom_byte == $past(s_reg.rom_byte)
        && ($past(i_reg_wr) || !s_reg.clr && !s_reg.rom_start))
        else $error("address clear misbehaved");

    AST_READ_BYTE: assert property (
        s_reg.go && rom_done && s_reg.boot == link_host_pkg::BOOT_RUN |=>
        !s_reg.go && s_reg.rom_byte == $past(rom_data))
        else $error("read byte not loaded");

    AST_GO_NEEDS_ROM: assert property (
        !s_reg.present |-> !s_reg.go && !s_reg.clr)
        else $error("EEPROM access without EEPROM");

    AST_MINI_VALID: assert property (
        reg_read(`OFS_ROM_ACCESS) |=>
        o_mini_rom_valid == (o_reg_rdata[7:0] > 8'h39))
        else $error("mini-ROM validity wrong");
endmodule

// >>> sim/eeprom_model.sv
`timescale 1ns/1ps
// ------
// serial eeprom stand-in, 4-phase req/ack
// ------
module eeprom_model (
    input  wire logic       i_ref_clk,
    input  wire logic       i_rom_req,
    input  wire logic [7:0] i_rom_addr,
    input  wire logic [3:0] i_delay,
    output logic            o_rom_ack,
    output logic [7:0]      o_rom_data
);
    int wait_cnt;
    initial begin
        o_rom_ack  = 1'b0;
        o_rom_data = 8'h00;
        forever begin
            @(posedge i_ref_clk);
            if (i_rom_req === 1'b1 && !o_rom_ack) begin
                wait_cnt = i_delay;
                repeat (wait_cnt) @(posedge i_ref_clk);
                o_rom_data <= (i_rom_addr == 8'h28) ? 8'h4C
                                                    : i_rom_addr ^ 8'h5A;
                o_rom_ack  <= 1'b1;
            end else if (i_rom_req === 1'b0 && o_rom_ack) begin
                // released bus: show something other than the last byte
                o_rom_ack  <= 1'b0;
                o_rom_data <= ~o_rom_data;
            end
        end
    end
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`include "link_host_params.svh"
module tb_top;
    localparam logic [7:0] MAJ = 8'h3C; // arbitrary value
    localparam logic [7:0] MNR = 8'h07; // arbitrary value
    logic        i_ref_clk, i_rstn, i_reg_wr, i_reg_rd, i_rom_present;
    logic        o_reg_rvalid, o_rom_req, i_rom_ack, o_store_and_forward;
    logic        o_mini_rom_valid, o_boot_done;
    logic [7:0]  i_reg_addr, o_rom_addr, i_rom_data, o_mini_rom_offset;
    logic [3:0]  o_phys_response_retry_count, o_async_response_retry_count;
    logic [3:0]  o_async_request_retry_count, dly;
    logic [31:0] i_reg_wdata, o_reg_rdata, o_rom_header, got, w;
    logic [63:0] notes[$];
    logic [63:0] note;
    int          err_total, comparisons;

    link_host_config_regs #(.VERSION_MAJOR(MAJ), .VERSION_MINOR(MNR)) dut (
        .i_ref_clk, .i_rstn, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
        .o_reg_rdata, .o_reg_rvalid, .i_rom_present, .o_rom_req, .o_rom_addr,
        .i_rom_ack, .i_rom_data, .o_phys_response_retry_count,
        .o_async_response_retry_count, .o_async_request_retry_count,
        .o_store_and_forward, .o_mini_rom_offset, .o_mini_rom_valid,
        .o_rom_header, .o_boot_done);
    eeprom_model rom (.i_ref_clk, .i_rom_req(o_rom_req),
        .i_rom_addr(o_rom_addr), .i_delay(dly), .o_rom_ack(i_rom_ack),
        .o_rom_data(i_rom_data));

    // ------
    // checking tasks
    // ------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic give_up();
        err_total++;
        $display("mismatch at %0t: wait ran out", $time);
        results();
    endtask
    function automatic logic [7:0] romb(input logic [7:0] a);
        return (a == 8'h28) ? 8'h4C : a ^ 8'h5A;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge i_ref_clk);
        i_reg_wr    = 1'b1;
        i_reg_addr  = a;
        i_reg_wdata = d;
        @(negedge i_ref_clk);
        i_reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        int n;
        notes.push_back({m, e & m});
        @(negedge i_ref_clk);
        i_reg_rd   = 1'b1;
        i_reg_addr = a;
        @(negedge i_ref_clk);
        i_reg_rd = 1'b0;
        n = 0;
        while (o_reg_rvalid !== 1'b1) begin
            if (++n > 4) give_up();
            @(negedge i_ref_clk);
        end
        got = o_reg_rdata;
    endtask
    task automatic poll(input logic [7:0] a, input int b, input logic v);
        int n;
        n = 0;
        do begin
            rd(a, 32'h0, 32'h0);
            if (++n > 40) give_up();
        end while (got[b] !== v);
    endtask
    task automatic boot(input logic pres);
        int n;
        i_rom_present = pres;
        i_rstn = 1'b0;
        repeat (16) @(negedge i_ref_clk);
        check(o_rom_header, 32'h0);
        check(o_phys_response_retry_count, 4'h0);
        i_rstn = 1'b1;
        n = 0;
        while (o_boot_done !== 1'b1) begin
            if (++n > 200) give_up();
            @(negedge i_ref_clk);
        end
    endtask

    // ------
    // read monitor: oldest note against each answer
    // ------
    always @(negedge i_ref_clk) begin
        if (o_reg_rvalid === 1'b1) begin
            if (notes.size() == 0) begin
                err_total++;
                $display("mismatch at %0t: answer without read", $time);
            end else begin
                note = notes.pop_front();
                check(o_reg_rdata & note[63:32], note[31:0]);
            end
        end
    end

    initial begin
        i_ref_clk = 1'b0;
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end

    // ------
    // main sequence
    // ------
    initial begin
        {i_rstn, i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata, dly} = '0;
        i_rom_present = 1'b1;
        err_total = 0;
        comparisons = 0;
        void'($urandom(32'hF3EE));
        boot(1'b1);
        check(o_mini_rom_offset, 8'h4C);
        check(o_mini_rom_valid, 1'b1);
        wr(`OFS_VERSION, 32'hFFFFFFFF);
        rd(`OFS_VERSION, {7'h0, 1'b1, MAJ, 8'h0, MNR}, '1);
        rd(`OFS_CS_CONTROL, 32'h80000000, 32'hFFFFFFFC);
        rd(`OFS_RETRY, 32'h0, '1);
        wr(`OFS_ROM_ACCESS, 32'h80000000);
        poll(`OFS_ROM_ACCESS, 31, 1'b0);
        check(got & 32'hFF00FFFF, 32'h0000004C);
        for (int i = 0; i < 4; i++) begin
            dly = 4'($urandom_range(15));
            if (i == 3) wr(`OFS_ROM_ACCESS, 32'h80000000);
            if (i == 3) poll(`OFS_ROM_ACCESS, 31, 1'b0);
            if (i == 3) check(got[23:16], romb(8'h2));
            wr(`OFS_ROM_ACCESS, 32'h02000000);
            poll(`OFS_ROM_ACCESS, 25, 1'b0);
            check(got[23:16], romb(8'(i % 3)));
        end
        for (int i = 0; i < 4; i++) begin
            w = (i == 0) ? 32'hFFFFF000 : $urandom;
            wr(`OFS_RETRY, w);
            rd(`OFS_RETRY, {20'h0, w[11:0]}, '1);
            check(o_phys_response_retry_count, w[11:8]);
            check(o_async_response_retry_count, w[7:4]);
            check(o_async_request_retry_count, w[3:0]);
            check(o_store_and_forward, w[11:0] == 12'h0);
        end
        for (int s = 0; s < 4; s++) begin
            w = $urandom;
            wr(`OFS_CS_DATA, w);
            wr(`OFS_CS_COMPARE, `RESOURCE_RESET);
            rd(`OFS_CS_COMPARE, `RESOURCE_RESET, '1);
            wr(`OFS_CS_CONTROL, 32'(s));
            rd(`OFS_CS_CONTROL, 32'h0, 32'h80000000);
            poll(`OFS_CS_CONTROL, 31, 1'b1);
            check(got, {1'b1, 29'h0, 2'(s)});
            rd(`OFS_CS_DATA, `RESOURCE_RESET, '1);
            wr(`OFS_CS_COMPARE, 32'h0);
            wr(`OFS_CS_CONTROL, 32'(s));
            poll(`OFS_CS_CONTROL, 31, 1'b1);
            rd(`OFS_CS_DATA, w, '1);
        end
        w = $urandom;
        wr(`OFS_ROM_HEADER, w);
        rd(`OFS_ROM_HEADER, w, '1);
        check(o_rom_header, w);
        wr(8'h1C, w);
        rd(8'h1C, 32'h0, '1);
        boot(1'b0);
        rd(`OFS_VERSION, {8'h0, MAJ, 8'h0, MNR}, '1);
        check(o_mini_rom_valid, 1'b0);
        wr(`OFS_ROM_ACCESS, 32'h02000000);
        rd(`OFS_ROM_ACCESS, 32'h0, 32'hFF00FFFF);
        check(o_rom_req, 1'b0);
        results();
    end
endmodule
